//--- vip_pkg.sv
`default_nettype none
package vip_pkg;
	localparam int NUM_VEC       = 36;
	localparam int VEC_W         = 6;
	localparam int ADDR_W        = 21;
	localparam int BASE_W        = 16;
	localparam int BASE_SHIFT    = 7;
	localparam int LVL_W         = 2;
	localparam int ENTRY_WORDS   = 2;
	localparam int TARGET_BITS   = 19;
	localparam logic [15:0] VEC_BASE_RESET = 16'h0000;
	localparam logic [1:0] LVL_FIXED3 = 2'h3;
	localparam logic [1:0] LVL_DBG_MIN = 2'h1;
	localparam logic [1:0] LVL_PER_MAX = 2'h2;
	// vector groups
	localparam int VEC_FIXED_LO  = 2;
	localparam int VEC_FIXED_HI  = 5;
	localparam int VEC_SW2       = 14;
	localparam int VEC_SW1       = 15;
	localparam int VEC_SW0       = 16;
	localparam int VEC_PER_LO    = 17;
	localparam int VEC_FLASH_ERR = 22;
	localparam int VEC_FLASH_CC  = 23;
	localparam int VEC_FLASH_BE  = 24;
	localparam int VEC_CAN_LO    = 26;
	localparam int VEC_CAN_HI    = 29;
	// implemented vectors: 2-7, 9-11, 14-18, 20-24, 26-35
	localparam logic [35:0] VEC_IMPL = 36'hF_FDF7_CEFC;
	localparam logic [35:0] VEC_DEBUG = 36'h0_0000_0EC0;
endpackage : vip_pkg
`default_nettype wire

//--- vip_req_if.sv
`default_nettype none
interface vip_req_if;
	import vip_pkg::*;
	logic [NUM_VEC-1:0] pend;
	logic [NUM_VEC-1:0] ack;
	modport keeper (output pend, input ack);
	modport user   (input pend, output ack);
endinterface : vip_req_if
`default_nettype wire

//--- vip_pend.sv
`default_nettype none
module vip_pend
	import vip_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic [NUM_VEC-1:0] req,
	vip_req_if.keeper        port
);
	typedef struct packed {
		logic [NUM_VEC-1:0] pend;
	} vip_pend_state_type;
	vip_pend_state_type st_reg;
	vip_pend_state_type st_next;
	always_comb begin
		// set wins over acknowledge; reserved slots masked
		st_next.pend = ((st_reg.pend & ~port.ack) | req) & VEC_IMPL;
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end
	assign port.pend = st_reg.pend;
endmodule : vip_pend
`default_nettype wire

//--- vip_top.sv
`default_nettype none
module vip_top
	import vip_pkg::*;
(
	input  wire logic                 CLOCK,
	input  wire logic                 ARST_N,
	input  wire logic                 REQ_ILLEGAL,
	input  wire logic                 REQ_SWI3,
	input  wire logic                 REQ_STACK_OVF,
	input  wire logic                 REQ_MISALIGN,
	input  wire logic [4:0]           REQ_DEBUG,
	input  wire logic [2:0]           REQ_SWI_LOW,
	input  wire logic                 EXTERNAL_REQUEST_A,
	input  wire logic                 EXTERNAL_REQUEST_B,
	input  wire logic                 LOW_VOLTAGE_DETECTOR,
	input  wire logic                 REQ_PLL,
	input  wire logic [2:0]           FLASH_MODULE_REQ,
	input  wire logic [3:0]           CAN_REQ,
	input  wire logic [5:0]           GPIO_REQ,
	input  wire logic [2*NUM_VEC-1:0] LEVEL_CFG,
	input  wire logic [BASE_W-1:0]    VECTOR_BASE_REGISTER,
	input  wire logic [LVL_W-1:0]     CORE_LEVEL,
	input  wire logic                 CORE_ACK,
	output logic                      IRQ_VALID,
	output logic [VEC_W-1:0]          IRQ_VECTOR,
	output logic [LVL_W-1:0]          IRQ_LEVEL,
	output logic [ADDR_W-1:0]         FETCH_ADDR
);
	typedef struct packed {
		logic              valid;
		logic [VEC_W-1:0]  vec;
		logic [LVL_W-1:0]  lvl;
		logic [ADDR_W-1:0] addr;
	} vip_top_state_type;

	vip_top_state_type st_reg;
	vip_top_state_type st_next;
	logic              rst_n;
	// reset release chain lives apart: it is cleared by the pin, not by rst_n
	logic [1:0]        rst_sync_reg;
	logic [NUM_VEC-1:0] req;
	logic [NUM_VEC-1:0] ack;
	logic [LVL_W-1:0]  lvl [NUM_VEC];
	logic [NUM_VEC-1:0] elig [4];
	vip_req_if         rq ();

	always_ff @(posedge CLOCK or negedge ARST_N) begin
		if (!ARST_N) begin
			rst_sync_reg <= 2'h0;
		end else begin
			rst_sync_reg <= {rst_sync_reg[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_reg[1];

	// request vector; vectors 0,1 never requested, overlay only
	always_comb begin
		req = '0;
		req[VEC_FIXED_LO]     = REQ_ILLEGAL;
		req[VEC_FIXED_LO + 1] = REQ_SWI3;
		req[VEC_FIXED_LO + 2] = REQ_STACK_OVF;
		req[VEC_FIXED_HI]     = REQ_MISALIGN;
		req[7:6]   = REQ_DEBUG[1:0];
		req[11:9]  = REQ_DEBUG[4:2];
		req[VEC_SW2] = REQ_SWI_LOW[2];
		req[VEC_SW1] = REQ_SWI_LOW[1];
		req[VEC_SW0] = REQ_SWI_LOW[0];
		req[VEC_PER_LO]     = EXTERNAL_REQUEST_A;
		req[VEC_PER_LO + 1] = EXTERNAL_REQUEST_B;
		req[20] = LOW_VOLTAGE_DETECTOR;
		req[21] = REQ_PLL;
		req[VEC_FLASH_ERR] = FLASH_MODULE_REQ[0];
		req[VEC_FLASH_CC]  = FLASH_MODULE_REQ[1];
		req[VEC_FLASH_BE]  = FLASH_MODULE_REQ[2];
		req[VEC_CAN_HI:VEC_CAN_LO] = CAN_REQ;
		req[35:30] = GPIO_REQ;
	end

	vip_pend u_pend (
		.clk   (CLOCK),
		.rst_n (rst_n),
		.req   (req),
		.port  (rq.keeper)
	);

	// effective level per vector, clamped to allowed range
	genvar g;
	generate
		for (g = 0; g < NUM_VEC; g++) begin : g_lvl
			logic [LVL_W-1:0] c;
			assign c = LEVEL_CFG[2*g +: 2];
			if (g >= VEC_FIXED_LO && g <= VEC_FIXED_HI) begin : g_f
				assign lvl[g] = LVL_FIXED3;
			end else if (VEC_DEBUG[g]) begin : g_d
				assign lvl[g] = (c < LVL_DBG_MIN) ? LVL_DBG_MIN : c;
			end else if (g == VEC_SW2) begin : g_s2
				assign lvl[g] = 2'h2;
			end else if (g == VEC_SW1) begin : g_s1
				assign lvl[g] = 2'h1;
			end else if (g == VEC_SW0) begin : g_s0
				assign lvl[g] = 2'h0;
			end else begin : g_p
				assign lvl[g] = (c > LVL_PER_MAX) ? LVL_PER_MAX : c;
			end
			for (genvar l = 0; l < 4; l++) begin : g_e
				assign elig[l][g] = rq.pend[g] && (lvl[g] == LVL_W'(l));
			end
		end
	endgenerate

	// winner: highest level, then lowest vector; masked below core level
	always_comb begin
		st_next = st_reg;
		st_next.valid = 1'b0;
		ack = '0;
		for (int l = 0; l < 4; l++) begin
			if (elig[l] != '0 && l[LVL_W-1:0] >= CORE_LEVEL) begin
				st_next.valid = 1'b1;
				st_next.lvl = l[LVL_W-1:0];
				for (int v = NUM_VEC - 1; v >= 0; v--) begin
					if (elig[l][v]) begin
						st_next.vec = v[VEC_W-1:0];
					end
				end
			end
		end
		// base shifted to word address, two words per entry
		st_next.addr = ADDR_W'({VECTOR_BASE_REGISTER, {BASE_SHIFT{1'b0}}})
			+ ADDR_W'(ENTRY_WORDS * st_next.vec);
		if (CORE_ACK && st_reg.valid) begin
			ack[st_reg.vec] = 1'b1;
		end
	end
	assign rq.ack = ack;

	always_ff @(posedge CLOCK or negedge rst_n) begin
		if (!rst_n) begin
			st_reg.valid <= 1'b0;
			st_reg.vec   <= '0;
			st_reg.lvl   <= '0;
			st_reg.addr  <= '0;
		end else begin
			st_reg.valid <= st_next.valid & ~(CORE_ACK & st_reg.valid);
			st_reg.vec   <= st_next.vec;
			st_reg.lvl   <= st_next.lvl;
			st_reg.addr  <= st_next.addr;
		end
	end

	assign IRQ_VALID  = st_reg.valid;
	assign IRQ_VECTOR = st_reg.vec;
	assign IRQ_LEVEL  = st_reg.lvl;
	assign FETCH_ADDR = st_reg.addr;
endmodule : vip_top
`default_nettype wire

//--- vip_top_sva.sv
`default_nettype none
module vip_top_sva
	import vip_pkg::*;
(
	input wire logic              CLOCK,
	input wire logic              ARST_N,
	input wire logic              REQ_ILLEGAL,
	input wire logic [BASE_W-1:0] VECTOR_BASE_REGISTER,
	input wire logic              CORE_ACK,
	input wire logic              IRQ_VALID,
	input wire logic [VEC_W-1:0]  IRQ_VECTOR,
	input wire logic [LVL_W-1:0]  IRQ_LEVEL,
	input wire logic [ADDR_W-1:0] FETCH_ADDR
);
	default clocking @(posedge CLOCK); endclocking
	default disable iff (!ARST_N);
	chk_addr_form: assert property ($stable(VECTOR_BASE_REGISTER) && IRQ_VALID |->
		FETCH_ADDR == ADDR_W'({VECTOR_BASE_REGISTER, 7'h00}) + ADDR_W'({IRQ_VECTOR, 1'b0})) else $error("address");
	chk_fixed_lvl: assert property (IRQ_VALID && IRQ_VECTOR inside {[2:5]} |-> IRQ_LEVEL == 2'h3)
		else $error("fixed level");
	chk_dbg_lvl: assert property (IRQ_VALID && IRQ_VECTOR inside {[6:11]} |-> IRQ_LEVEL != 2'h0)
		else $error("debug level");
	chk_per_lvl: assert property (IRQ_VALID && IRQ_VECTOR > 6'h10 |-> IRQ_LEVEL != 2'h3)
		else $error("peripheral level");
	chk_no_resv: assert property (IRQ_VALID |-> !(IRQ_VECTOR inside {0, 1, 8, 12, 13, 19, 25}))
		else $error("reserved vector");
	chk_top_first: assert property (REQ_ILLEGAL && !CORE_ACK ##1 !CORE_ACK |=> IRQ_VALID && IRQ_LEVEL == 2'h3)
		else $error("level 3 late");
	chk_hold_pend: assert property (IRQ_VALID && !CORE_ACK |=> IRQ_VALID) else $error("request lost");
	chk_ack_gap: assert property (IRQ_VALID && CORE_ACK |=> !IRQ_VALID) else $error("no gap");
	cover property (IRQ_VALID && CORE_ACK);
	cover property (IRQ_VALID && IRQ_LEVEL == 2'h3);
	cover property (IRQ_VALID && IRQ_VECTOR == 6'h1D);
endmodule : vip_top_sva
bind vip_top vip_top_sva u_vip_top_sva (.CLOCK(CLOCK), .ARST_N(ARST_N), .REQ_ILLEGAL(REQ_ILLEGAL),
	.VECTOR_BASE_REGISTER(VECTOR_BASE_REGISTER), .CORE_ACK(CORE_ACK), .IRQ_VALID(IRQ_VALID),
	.IRQ_VECTOR(IRQ_VECTOR), .IRQ_LEVEL(IRQ_LEVEL), .FETCH_ADDR(FETCH_ADDR));
`default_nettype wire

//--- vip_core_model.sv
`default_nettype none
module vip_core_model (
	input  wire logic clk,
	input  wire logic irq_valid,
	input  wire logic hold,
	output var logic  core_ack
);
	timeunit 1ns;
	timeprecision 100ps;
	int n_reg = 0;
	initial core_ack = 1'b0;
	// takes a vector two cycles after it shows, unless stalled
	always @(posedge clk) begin
		n_reg <= (irq_valid && !core_ack) ? n_reg + 1 : 0;
		core_ack <= irq_valid && !core_ack && !hold && n_reg > 0;
	end
endmodule : vip_core_model
`default_nettype wire

//--- vip_top_test.sv
`default_nettype none
`define VIP_CHK(a, b) begin comparisons++; if ((a) !== (b)) begin n_mismatch++; \
	$display("[FAIL] %0t mismatch", $time); end end
module vip_top_test
	import vip_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	typedef struct {logic [35:0] m; logic [5:0] v; logic [1:0] l; int k;} vip_row_type;
	vip_row_type rows[8] = '{'{36'h0_01C0_0000, 6'h16, 2'h1, 3}, '{36'h0_3C00_0000, 6'h1A, 2'h1, 4},
		'{36'h0_2000_0000, 6'h1D, 2'h1, 1}, '{36'h8_0000_003C, 6'h02, 2'h3, 5}, '{36'h8_4000_0000, 6'h23, 2'h2, 2},
		'{36'h0_0004_0000, 6'h12, 2'h2, 1}, '{36'h0_0010_0040, 6'h06, 2'h1, 2}, '{36'h0_0001_C000, 6'h0E, 2'h2, 3}};
	logic        clk = 1'b0, arst_n = 1'b0, hold = 1'b1, ack, vld;
	logic [35:0] r = '0;
	logic [71:0] lc = {2'h2, {16{2'b01}}, 2'h3, {11{2'b01}}, 2'h0, {6{2'b01}}};
	logic [15:0] base = 16'h0000;
	logic [1:0]  cl = 2'h0, lvl;
	logic [5:0]  vec;
	logic [20:0] fa;
	int          n_mismatch = 0, comparisons = 0, n_ack = 0;
	vip_top u_vip_top (.CLOCK(clk), .ARST_N(arst_n), .REQ_ILLEGAL(r[2]), .REQ_SWI3(r[3]), .REQ_STACK_OVF(r[4]),
		.REQ_MISALIGN(r[5]), .REQ_DEBUG({r[11:9], r[7:6]}), .REQ_SWI_LOW({r[14], r[15], r[16]}),
		.EXTERNAL_REQUEST_A(r[17]), .EXTERNAL_REQUEST_B(r[18]), .LOW_VOLTAGE_DETECTOR(r[20]), .REQ_PLL(r[21]),
		.FLASH_MODULE_REQ(r[24:22]), .CAN_REQ(r[29:26]), .GPIO_REQ(r[35:30]), .LEVEL_CFG(lc),
		.VECTOR_BASE_REGISTER(base), .CORE_LEVEL(cl), .CORE_ACK(ack), .IRQ_VALID(vld), .IRQ_VECTOR(vec),
		.IRQ_LEVEL(lvl), .FETCH_ADDR(fa));
	vip_core_model u_vip_core_model (.clk(clk), .irq_valid(vld), .hold(hold), .core_ack(ack));
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#2;
	endtask : step
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : give_verdict
	initial forever #12.5 clk = ~clk;
	always @(posedge clk) if (ack && vld) n_ack++;
	initial begin
		#30us;
		n_mismatch++;
		give_verdict();
	end
	initial begin
		step(5);
		`VIP_CHK({vld, fa}, 22'h00_0000)
		arst_n = 1'b1;
		step(4);
		foreach (rows[i]) begin
			base = 16'h00A0 + 16'(i);
			hold = 1'b1;
			n_ack = 0;
			r = rows[i].m;
			step(1);
			r = '0;
			step(3);
			`VIP_CHK({vld, vec, lvl}, {1'b1, rows[i].v, rows[i].l})
			`VIP_CHK(fa, 21'({base, 7'h00}) + 21'({rows[i].v, 1'b0}))
			`VIP_CHK(fa - 21'({base, 7'h00}) >= 21'h00_0004, 1'b1)
			hold = 1'b0;
			step(30);
			`VIP_CHK(n_ack, rows[i].k)
			$display("row %0d done", i);
		end
		hold = 1'b1;
		cl = 2'h2;
		r = 36'h0_4000_0000;
		step(1);
		r = '0;
		step(4);
		`VIP_CHK(vld, 1'b0)
		cl = 2'h0;
		step(3);
		`VIP_CHK({vld, vec}, 7'h5E)
		arst_n = 1'b0;
		step(1);
		`VIP_CHK(vld, 1'b0)
		arst_n = 1'b1;
		step(5);
		`VIP_CHK(vld, 1'b0)
		$display("mask and reset tests done");
		give_verdict();
	end
endmodule : vip_top_test
`default_nettype wire
